/* File: verilog/csfe_node.sv */
// How it works
// - overridden frames are resent automatically
// - bus left recessive between frames
// - fields: start, 12, 6, data, 16, 2, end
// - stuffing from start bit through CRC
// - stuff opposite bit after five equal
// - single dominant start bit only when idle
// - request bit dominant data, recessive remote
// - two dominant reserved bits, four-bit length
// - length code gives zero to eight bytes
// - sender recessive ack slot, receivers drive dominant
// - seven recessive end-of-frame bits close frame
// - three-bit intermission; dominant there means overload
`timescale 1ns/100ps
module csfe_node
  import csfe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic can_rx,
  output logic can_tx_out,
  output logic can_tx_oe,
  input wire logic tx_req,
  output logic tx_ready,
  input wire logic [10:0] tx_id,
  input wire logic tx_rtr,
  input wire logic [3:0] tx_dlc,
  input wire logic tx_data_valid,
  output logic tx_data_ready,
  input wire logic [BYTE_W-1:0] tx_data,
  output logic tx_done,
  output logic arb_lost,
  output logic err_seen,
  output logic [BYTE_W-1:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_done,
  output logic [10:0] rx_id,
  output logic rx_rtr,
  output logic [3:0] rx_dlc
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    csfe_state_t st;
    logic [6:0] cnt;
    logic [2:0] run;
    logic last;
    logic txing;
    logic ack_me;
    logic drv_dom;
    logic [14:0] crc;
    logic [11:0] sh;
    logic [3:0] dlc;
    logic [3:0] nb;
    logic [7:0] byte_sh;
    logic pend;
    logic [10:0] p_id;
    logic p_rtr;
    logic [3:0] p_dlc;
    logic [3:0] p_nb;
    logic [3:0] ld;
    logic [7:0][BYTE_W-1:0] tbuf;
    logic [BYTE_W-1:0] o_byte;
    logic o_byte_v;
    logic o_rx_done;
    logic o_tx_done;
    logic o_err;
    logic o_arb_lost;
    logic [10:0] o_id;
    logic o_rtr;
    logic [3:0] o_dlc;
    logic [8:0] transmit_error_count;
    logic [7:0] receive_error_count;
    logic [3:0] susp;
  } csfe_node_st_t;

  csfe_node_st_t r_reg, r_next;
  logic tx_pt, smp_pt, hard_sync;
  logic err_passive, bus_off;
  logic q_valid, q_ready;
  logic [BYTE_W-1:0] q_data;

  // bytes wait here until a frame request is pending, then move out to the frame buffer; a full queue stalls the user
  csfe_fifo #(.W(BYTE_W), .D(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_valid(tx_data_valid),
    .in_ready(tx_data_ready),
    .in_data(tx_data),
    .out_valid(q_valid),
    .out_ready(q_ready),
    .out_data(q_data)
  );

  // only an edge seen from idle resynchronises the bit grid
  assign hard_sync = (r_reg.st == CSFE_IDLE) && r_reg.s3 && !r_reg.s2;

  // fault state from the counts; bus-off is sticky until reset, there is no recovery path
  assign err_passive = r_reg.transmit_error_count[7] || r_reg.receive_error_count[7];
  assign bus_off = r_reg.transmit_error_count[8];

  csfe_bit_timer u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .bit_div(bit_div),
    .hard_sync(hard_sync),
    .tx_pt(tx_pt),
    .smp_pt(smp_pt)
  );

  // open drain: the pin only ever pulls dominant
  assign can_tx_out = 1'b0;
  assign can_tx_oe = r_reg.drv_dom;
  assign tx_ready = !r_reg.pend;
  assign q_ready = r_reg.pend && (r_reg.ld != r_reg.p_nb);
  assign tx_done = r_reg.o_tx_done;
  assign arb_lost = r_reg.o_arb_lost;
  assign err_seen = r_reg.o_err;
  assign rx_byte = r_reg.o_byte;
  assign rx_byte_valid = r_reg.o_byte_v;
  assign rx_done = r_reg.o_rx_done;
  assign rx_id = r_reg.o_id;
  assign rx_rtr = r_reg.o_rtr;
  assign rx_dlc = r_reg.o_dlc;

  // next state of the whole node, stepped at drive and sample strobes
  always_comb
  begin
    logic b, stuffed, err, tbit, fb;
    logic [11:0] ab;
    logic [3:0] dl;
    b = r_reg.s2;
    err = 1'b0;
    tbit = 1'b1;
    ab = {r_reg.p_id, r_reg.p_rtr};
    dl = 4'h0;
    fb = 1'b0;
    stuffed = (r_reg.st == CSFE_ARB) || (r_reg.st == CSFE_CTRL) ||
              (r_reg.st == CSFE_DATA) || (r_reg.st == CSFE_CRC) ||
              ((r_reg.st == CSFE_CRC_DELIM) && (r_reg.run == STUFF_RUN));
    r_next = r_reg;
    r_next.s1 = can_rx;
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    r_next.o_byte_v = 1'b0;
    r_next.o_rx_done = 1'b0;
    r_next.o_tx_done = 1'b0;
    r_next.o_err = 1'b0;
    r_next.o_arb_lost = 1'b0;

    // accept a frame request, then pull its data bytes from the queue
    if (tx_req && !r_reg.pend)
    begin
      r_next.pend = 1'b1;
      r_next.p_id = tx_id;
      r_next.p_rtr = tx_rtr;
      r_next.p_dlc = tx_dlc;
      r_next.p_nb = tx_rtr ? 4'h0 : ((tx_dlc > MAX_BYTES) ? MAX_BYTES : tx_dlc);
      r_next.ld = 4'h0;
    end
    if (q_valid && q_ready)
    begin
      r_next.tbuf[r_reg.ld[2:0]] = q_data;
      r_next.ld = r_reg.ld + 4'h1;
    end

    // choose the level to present for the coming bit
    if (tx_pt)
    begin
      unique case (r_reg.st)
        CSFE_IDLE:
        begin
          // start bit only from idle, once the whole frame is loaded
          if (r_reg.pend && (r_reg.ld == r_reg.p_nb) && !bus_off && (r_reg.susp == 4'h0))
          begin
            tbit = 1'b0;
            r_next.txing = 1'b1;
          end
        end
        CSFE_ARB:
          tbit = ab[4'(ARB_LAST - r_reg.cnt)];
        CSFE_CTRL:
          tbit = (r_reg.cnt <= CTRL_RSV_LAST) ? 1'b0 : r_reg.p_dlc[2'(CTRL_LAST - r_reg.cnt)];
        CSFE_DATA:
          tbit = r_reg.tbuf[r_reg.cnt[5:3]][BYTE_LAST - r_reg.cnt[2:0]];
        CSFE_CRC:
          tbit = r_reg.crc[14];
        CSFE_ACK:
          tbit = !r_reg.ack_me;
        CSFE_FLAG:
          tbit = 1'b0;
        default:
          tbit = 1'b1;
      endcase
      if (stuffed && (r_reg.run == STUFF_RUN))
        tbit = !r_reg.last;
      if (stuffed && !r_reg.txing)
        tbit = 1'b1;
      // a passive node's flag stays recessive; bus-off never pulls the line
      r_next.drv_dom = !tbit && !bus_off && ((r_reg.st == CSFE_IDLE) || r_reg.txing ||
                       (r_reg.st == CSFE_ACK) || ((r_reg.st == CSFE_FLAG) && !err_passive));
    end

    // evaluate the sampled bus level
    if (smp_pt)
    begin
      if (stuffed && (r_reg.run == STUFF_RUN))
      begin
        // stuff bit: must differ, carries no data and no crc
        if (b == r_reg.last)
          err = 1'b1;
        else if (r_reg.txing && (b == r_reg.drv_dom))
          err = 1'b1;
        r_next.run = 3'h1;
        r_next.last = b;
      end
      else
      begin
        if (stuffed)
        begin
          r_next.run = (b == r_reg.last) ? r_reg.run + 3'h1 : 3'h1;
          r_next.last = b;
          fb = b ^ r_reg.crc[14];
          // while sending the sequence fb is zero, so the register just shifts out
          r_next.crc = {r_reg.crc[13:0], 1'b0} ^ (fb ? CRC_POLY : CRC_INIT);
          if (r_reg.txing && (b == r_reg.drv_dom))
          begin
            if ((r_reg.st == CSFE_ARB) && !b)
            begin
              r_next.txing = 1'b0;
              r_next.o_arb_lost = 1'b1;
            end
            else
              err = 1'b1;
          end
        end
        r_next.cnt = r_reg.cnt + 7'h01;
        unique case (r_reg.st)
          CSFE_IDLE:
          begin
            r_next.cnt = 7'h00;
            if (!b)
            begin
              // start bit: dominant and run of one; crc of a zero bit stays zero
              r_next.st = CSFE_ARB;
              r_next.run = 3'h1;
              r_next.last = 1'b0;
              r_next.crc = CRC_INIT;
              r_next.ack_me = 1'b0;
              r_next.susp = 4'h0;
            end
            else
            begin
              r_next.txing = 1'b0;
              if (r_reg.susp != 4'h0)
                r_next.susp = r_reg.susp - 4'h1;
            end
          end
          CSFE_ARB:
          begin
            r_next.sh = {r_reg.sh[10:0], b};
            if (r_reg.cnt == ARB_LAST)
            begin
              r_next.st = CSFE_CTRL;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_CTRL:
          begin
            dl = {r_reg.dlc[2:0], b};
            if ((r_reg.cnt == 7'h00) && b)
            begin
              // long identifier: step aside until the bus settles
              r_next.st = CSFE_EXT;
              r_next.cnt = 7'h00;
              r_next.txing = 1'b0;
            end
            else if (r_reg.cnt > CTRL_RSV_LAST)
              r_next.dlc = dl;
            if (!((r_reg.cnt == 7'h00) && b) && (r_reg.cnt == CTRL_LAST))
            begin
              r_next.nb = r_reg.sh[0] ? 4'h0 : ((dl > MAX_BYTES) ? MAX_BYTES : dl);
              r_next.st = (r_reg.sh[0] || (dl == 4'h0)) ? CSFE_CRC : CSFE_DATA;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_DATA:
          begin
            r_next.byte_sh = {r_reg.byte_sh[6:0], b};
            if (r_reg.cnt[2:0] == BYTE_LAST)
            begin
              r_next.o_byte = {r_reg.byte_sh[6:0], b};
              r_next.o_byte_v = !r_reg.txing;
            end
            if (r_reg.cnt == {r_reg.nb, 3'h0} - 7'h01)
            begin
              r_next.st = CSFE_CRC;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_CRC:
          begin
            if (r_reg.cnt == CRC_LAST)
              r_next.st = CSFE_CRC_DELIM;
          end
          CSFE_CRC_DELIM:
          begin
            if (!b)
              err = 1'b1;
            r_next.ack_me = !r_reg.txing && (r_reg.crc == CRC_INIT);
            r_next.st = CSFE_ACK;
          end
          CSFE_ACK:
          begin
            if (r_reg.txing && b)
              err = 1'b1;
            r_next.ack_me = 1'b0;
            r_next.st = CSFE_ACK_DELIM;
          end
          CSFE_ACK_DELIM:
          begin
            // crc fault is flagged only after the ack delimiter
            if (!b || (!r_reg.txing && (r_reg.crc != CRC_INIT)))
              err = 1'b1;
            r_next.st = CSFE_EOF;
            r_next.cnt = 7'h00;
          end
          CSFE_EOF:
          begin
            if (!b)
              err = 1'b1;
            else if (!r_reg.txing && (r_reg.cnt == EOF_RX_VALID))
            begin
              r_next.o_rx_done = 1'b1;
              if (r_reg.receive_error_count != 8'h00)
                r_next.receive_error_count = r_reg.receive_error_count - 8'h01;
              r_next.o_id = r_reg.sh[11:1];
              r_next.o_rtr = r_reg.sh[0];
              r_next.o_dlc = r_reg.dlc;
            end
            if (b && (r_reg.cnt == EOF_LAST))
            begin
              if (r_reg.txing)
              begin
                r_next.pend = 1'b0;
                r_next.o_tx_done = 1'b1;
                if (!bus_off && (r_reg.transmit_error_count != 9'h000))
                  r_next.transmit_error_count = r_reg.transmit_error_count - 9'h001;
                r_next.susp = err_passive ? SUSPEND_BITS : 4'h0;
              end
              r_next.txing = 1'b0;
              r_next.st = CSFE_INTER;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_INTER:
          begin
            if (!b)
            begin
              // a dominant bit here is an overload; answer with a flag of our own
              r_next.st = CSFE_FLAG;
              r_next.cnt = 7'h00;
            end
            else if (r_reg.cnt == INTER_LAST)
              r_next.st = CSFE_IDLE;
          end
          CSFE_FLAG:
          begin
            if (r_reg.cnt == FLAG_LAST)
            begin
              r_next.st = CSFE_DELIM;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_DELIM:
          begin
            // other nodes' flags may overlap; count only recessive bits
            r_next.cnt = b ? r_reg.cnt + 7'h01 : 7'h00;
            if (b && (r_reg.cnt == DELIM_LAST))
            begin
              r_next.st = CSFE_INTER;
              r_next.cnt = 7'h00;
            end
          end
          CSFE_EXT:
          begin
            r_next.cnt = b ? r_reg.cnt + 7'h01 : 7'h00;
            if (b && (r_reg.cnt == EXT_IDLE_LAST))
              r_next.st = CSFE_IDLE;
          end
          default:
            r_next.st = CSFE_IDLE;
        endcase
      end
      // any error aborts the frame; the pending frame stays for a resend
      if (err && (r_reg.st != CSFE_FLAG) && (r_reg.st != CSFE_DELIM) && (r_reg.st != CSFE_EXT))
      begin
        r_next.st = CSFE_FLAG;
        r_next.cnt = 7'h00;
        r_next.txing = 1'b0;
        r_next.ack_me = 1'b0;
        r_next.o_err = 1'b1;
        if (r_reg.txing && !bus_off)
          r_next.transmit_error_count = r_reg.transmit_error_count + TX_ERR_STEP;
        else if (!r_reg.txing && !r_reg.receive_error_count[7])
          r_next.receive_error_count = r_reg.receive_error_count + RX_ERR_STEP;
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      r_reg <= '0;
      r_reg.s1 <= 1'b1;
      r_reg.s2 <= 1'b1;
      r_reg.s3 <= 1'b1;
      r_reg.st <= CSFE_INTER;
    end
    else
      r_reg <= r_next;
  end

endmodule // csfe_node

/* File: verilog/csfe_pkg.sv */
package csfe_pkg;

  // frame field lengths, expressed as the value of the bit counter on the last bit
  localparam logic [6:0] ARB_LAST = 7'h0B;  // 11 identifier bits plus request bit
  localparam logic [6:0] CTRL_LAST = 7'h05;  // two reserved bits plus four-bit length code
  localparam logic [6:0] CTRL_RSV_LAST = 7'h01;
  localparam logic [6:0] CRC_LAST = 7'h0E;  // 15-bit sequence
  localparam logic [6:0] EOF_LAST = 7'h06;  // seven end-of-frame bits
  localparam logic [6:0] EOF_RX_VALID = 7'h05;  // penultimate end-of-frame bit
  localparam logic [6:0] INTER_LAST = 7'h02;  // three intermission bits
  localparam logic [6:0] FLAG_LAST = 7'h05;  // six flag bits
  localparam logic [6:0] DELIM_LAST = 7'h07;  // eight delimiter bits
  localparam logic [6:0] EXT_IDLE_LAST = 7'h0A;  // eleven recessive bits to resync
  localparam logic [2:0] BYTE_LAST = 3'h7;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  localparam logic [14:0] CRC_POLY = 15'h4599;
  localparam logic [14:0] CRC_INIT = 15'h0000;
  // fault counting: a failed send weighs more than a failed receive
  localparam logic [8:0] TX_ERR_STEP = 9'h008;
  localparam logic [7:0] RX_ERR_STEP = 8'h01;
  localparam logic [3:0] SUSPEND_BITS = 4'h8;  // recessive bits a passive sender waits
  localparam int BYTE_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int DIV_W = 16;

  typedef enum logic [3:0] {
    CSFE_IDLE,
    CSFE_ARB,
    CSFE_CTRL,
    CSFE_DATA,
    CSFE_CRC,
    CSFE_CRC_DELIM,
    CSFE_ACK,
    CSFE_ACK_DELIM,
    CSFE_EOF,
    CSFE_INTER,
    CSFE_FLAG,
    CSFE_DELIM,
    CSFE_EXT
  } csfe_state_t;

endpackage

/* File: verilog/csfe_fifo.sv */
`timescale 1ns/100ps
module csfe_fifo
  import csfe_pkg::*;
#(
  parameter int W = 8,
  parameter int D = 8
)(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } csfe_fifo_st_t;

  csfe_fifo_st_t r_reg, r_next;
  logic push, pop;

  // full and empty come straight from the fill count
  assign in_ready = r_reg.cnt != (AW+1)'(D);
  assign out_valid = r_reg.cnt != '0;
  assign out_data = r_reg.mem[r_reg.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers wrap at the depth, which need not be a power of two
  always_comb
  begin
    r_next = r_reg;
    if (push)
    begin
      r_next.mem[r_reg.wp] = in_data;
      r_next.wp = (r_reg.wp == AW'(D-1)) ? '0 : r_reg.wp + 1'b1;
    end
    if (pop)
      r_next.rp = (r_reg.rp == AW'(D-1)) ? '0 : r_reg.rp + 1'b1;
    r_next.cnt = r_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

endmodule // csfe_fifo

/* File: verilog/csfe_bit_timer.sv */
`timescale 1ns/100ps
module csfe_bit_timer
  import csfe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic hard_sync,
  output logic tx_pt,
  output logic smp_pt
);

  typedef struct packed {
    logic [DIV_W-1:0] cnt;
  } csfe_timer_st_t;

  csfe_timer_st_t r_reg, r_next;

  // drive at the bit start, sample in the middle of the bit
  assign tx_pt = r_reg.cnt == '0;
  assign smp_pt = r_reg.cnt == (bit_div >> 1);

  // a falling edge out of idle restarts the bit; the edge itself was bit start
  always_comb
  begin
    r_next = r_reg;
    if (hard_sync)
      r_next.cnt = DIV_W'(1);
    else if (r_reg.cnt >= bit_div - 1'b1)
      r_next.cnt = '0;
    else
      r_next.cnt = r_reg.cnt + 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      r_reg <= '0;
    else
      r_reg <= r_next;
  end

endmodule // csfe_bit_timer

/* File: verification/csfe_node_chk_sva.sv */
`timescale 1ns/100ps
module csfe_node_chk
  import csfe_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic can_tx_out,
  input wire logic can_tx_oe,
  input wire logic tx_req,
  input wire logic tx_ready,
  input wire logic tx_done,
  input wire logic arb_lost,
  input wire logic err_seen,
  input wire logic rx_done
);
  typedef struct packed {
    logic [19:0] run;
    logic [19:0] wait_n;
    logic pend;
  } csfe_chk_t;
  csfe_chk_t chk_reg, chk_next;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // dominant run length, and the wait from an error report to its flag
  always_comb
  begin
    chk_next.run = can_tx_oe ? chk_reg.run + 20'h00001 : 20'h00000;
    chk_next.pend = err_seen || (chk_reg.pend && !can_tx_oe);
    chk_next.wait_n = chk_next.pend ? chk_reg.wait_n + 20'h00001 : 20'h00000;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      chk_reg <= '0;
    else
      chk_reg <= chk_next;
  end

  property p_reset_quiet;
    $rose(rst_n) |-> !can_tx_oe && tx_ready && !tx_done;
  endproperty
  property p_open_drain;
    can_tx_out == 1'b0;
  endproperty
  property p_take;
    tx_req && tx_ready |=> !tx_ready;
  endproperty
  property p_done;
    tx_done |-> !can_tx_oe ##1 tx_ready;
  endproperty
  property p_yield;
    arb_lost |-> (!can_tx_oe) [*8];
  endproperty
  property p_retry;
    arb_lost |-> (!tx_ready) [*4];
  endproperty
  // error flag plus up to six dominant bits before it is the longest legal run
  property p_run;
    chk_reg.run <= 12 * bit_div + 4;
  endproperty
  property p_flag;
    chk_reg.wait_n <= 4 * bit_div;
  endproperty
  property p_rx_quiet;
    rx_done |-> !can_tx_oe && !tx_done;
  endproperty

  a_reset_quiet: assert property (p_reset_quiet) else $error("bus driven or busy after reset");
  a_open_drain: assert property (p_open_drain) else $error("data line not held low");
  a_take: assert property (p_take) else $error("request taken but ready stayed high");
  a_done: assert property (p_done) else $error("frame end not recessive or not ready");
  a_yield: assert property (p_yield) else $error("still driving after losing");
  a_retry: assert property (p_retry) else $error("lost frame dropped");
  a_run: assert property (p_run) else $error("dominant run too long");
  a_flag: assert property (p_flag) else $error("no flag after error report");
  a_rx_quiet: assert property (p_rx_quiet) else $error("driving at receive end");

  c_sent: cover property (tx_done);
  c_lost: cover property (arb_lost);
  c_err: cover property (err_seen);
  c_rx: cover property (rx_done);
endmodule // csfe_node_chk

bind csfe_node csfe_node_chk chk_u (
  .mclk(mclk),
  .rst_n(rst_n),
  .bit_div(bit_div),
  .can_tx_out(can_tx_out),
  .can_tx_oe(can_tx_oe),
  .tx_req(tx_req),
  .tx_ready(tx_ready),
  .tx_done(tx_done),
  .arb_lost(arb_lost),
  .err_seen(err_seen),
  .rx_done(rx_done)
);

/* File: verification/csfe_peer_model.sv */
`timescale 1ns/100ps
// far-side node: receives, acknowledges good frames, sends queued ones
module csfe_peer_model
  import csfe_pkg::*;
(
  input wire logic mclk,
  input wire logic can_bus,
  output logic peer_oe
);
  logic [3:0] cnt = 4'h0;
  logic prev = 1'b1, in_frame = 1'b0, sending = 1'b0, last = 1'b0, ack_seen = 1'b0;
  logic [14:0] crc = 15'h0000;
  logic rxb [0:127];
  logic txq [$];
  int idx = 0, run = 0, idle_n = 0, ack = 200, n;

  initial peer_oe = 1'b0;

  // bit clock of eight cycles, drive at count 0, sample mid-bit
  always @(posedge mclk)
  begin
    prev <= can_bus;
    cnt <= (cnt == 4'h7) ? 4'h0 : cnt + 4'h1;
    if (!in_frame && !sending && prev && !can_bus)
      cnt <= 4'h1;
    if (cnt == 4'h0)
      drive();
    if (cnt == 4'h4)
      sample(can_bus);
  end

  task automatic drive();
    if (sending && txq.size() > 0)
      peer_oe <= !txq.pop_front();
    else
      peer_oe <= in_frame && !sending && idx == ack && crc == 15'h0000;
    if (!in_frame && !sending && txq.size() > 0 && idle_n >= 3)
    begin
      sending = 1'b1;
      peer_oe <= !txq.pop_front();
    end
  endtask

  // destuff and collect; a sender that reads dominant over its recessive in the first 13 bits backs off
  task automatic sample(input logic s);
    if (!in_frame)
    begin
      if (!s && idle_n >= 3)
      begin
        in_frame = 1'b1;
        idx = 1;
        run = 1;
        last = 1'b0;
        ack = 200;
        crc = 15'h0000;
        rxb[0] = 1'b0;
      end
      idle_n = s ? idle_n + 1 : 0;
    end
    else if (run == 5 && idx < ack)
    begin
      run = 1;
      last = s;
    end
    else
    begin
      if (sending && !peer_oe && !s && idx < 13)
      begin
        sending = 1'b0;
        txq.delete();
      end
      rxb[idx] = s;
      run = (s == last) ? run + 1 : 1;
      last = s;
      if (idx < ack - 1)
        crc = {crc[13:0], 1'b0} ^ ((s ^ crc[14]) ? CRC_POLY : 15'h0000);
      if (idx == 18)
      begin
        n = {rxb[15], rxb[16], rxb[17], rxb[18]};
        ack = 35 + (rxb[12] ? 0 : 8 * ((n > 8) ? 8 : n));
      end
      if (idx == ack)
        ack_seen = !s;
      if (idx == ack + 8)
      begin
        in_frame = 1'b0;
        sending = 1'b0;
      end
      idx = idx + 1;
    end
  endtask

  // queue one frame; bad flips the last crc bit so receivers must reject it
  task automatic send(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d,
                      input logic bad);
    logic raw [$];
    logic [14:0] c;
    logic [18:0] hdr;
    logic lv;
    int k, r;
    hdr = {1'b0, id, rtr, 2'b00, dlc};
    c = 15'h0000;
    lv = 1'b1;
    r = 0;
    for (k = 18; k >= 0; k--)
      raw.push_back(hdr[k]);
    for (k = 0; k < (rtr ? 0 : 8 * ((dlc > 8) ? 8 : dlc)); k++)
      raw.push_back(d[63 - k]);
    foreach (raw[i])
      c = {c[13:0], 1'b0} ^ ((raw[i] ^ c[14]) ? CRC_POLY : 15'h0000);
    for (k = 14; k >= 0; k--)
      raw.push_back(c[k] ^ (bad && k == 0));
    foreach (raw[i])
    begin
      txq.push_back(raw[i]);
      r = (raw[i] == lv) ? r + 1 : 1;
      lv = raw[i];
      if (r == 5)
      begin
        txq.push_back(!lv);
        lv = !lv;
        r = 1;
      end
    end
  endtask
endmodule // csfe_peer_model

/* File: verification/csfe_node_bench.sv */
`timescale 1ns/100ps
module csfe_node_bench
  import csfe_pkg::*;
;
  localparam logic [63:0] DATA_A = 64'h00FF_0F80_7E01_F8C3;
  logic mclk = 1'b0, rst_n = 1'b0, tx_req = 1'b0, tx_rtr = 1'b0, tx_data_valid = 1'b0;
  logic [10:0] tx_id = 11'h000;
  logic [3:0] tx_dlc = 4'h0;
  logic [7:0] tx_data = 8'h00;
  logic can_rx, can_tx_out, can_tx_oe, tx_ready, tx_data_ready, tx_done, arb_lost, err_seen;
  logic rx_byte_valid, rx_done, rx_rtr, peer_oe;
  logic [7:0] rx_byte;
  logic [10:0] rx_id;
  logic [3:0] rx_dlc;
  logic [63:0] rxq = 64'h0;
  int failures = 0, n_checks = 0;
  int ev [4] = '{0, 0, 0, 0};

  initial forever #2.5 mclk = ~mclk;

  // open-drain bus: any enabled driver pulls it dominant
  assign can_rx = ~(can_tx_oe | peer_oe);

  csfe_node dut_u (.mclk(mclk), .rst_n(rst_n), .bit_div(16'h0008), .can_rx(can_rx), .can_tx_out(can_tx_out),
    .can_tx_oe(can_tx_oe), .tx_req(tx_req), .tx_ready(tx_ready), .tx_id(tx_id), .tx_rtr(tx_rtr),
    .tx_dlc(tx_dlc), .tx_data_valid(tx_data_valid), .tx_data_ready(tx_data_ready), .tx_data(tx_data),
    .tx_done(tx_done), .arb_lost(arb_lost), .err_seen(err_seen), .rx_byte(rx_byte),
    .rx_byte_valid(rx_byte_valid), .rx_done(rx_done), .rx_id(rx_id), .rx_rtr(rx_rtr), .rx_dlc(rx_dlc));
  csfe_peer_model peer_u (.mclk(mclk), .can_bus(can_rx), .peer_oe(peer_oe));

  // count pulses so waits never miss a one-cycle event
  always @(posedge mclk)
  begin
    if (tx_done) ev[0]++;
    if (arb_lost) ev[1]++;
    if (err_seen) ev[2]++;
    if (rx_done) ev[3]++;
    if (rx_byte_valid) rxq <= {rxq[55:0], rx_byte};
  end

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_ev(input int k, input int n);
    int i;
    for (i = 0; i < 20000 && ev[k] < n; i++)
      @(negedge mclk);
    check(64'(ev[k] >= n), 64'h1);
    if (ev[k] < n)
      finish_test();
  endtask

  task automatic push(input logic [7:0] b);
    @(negedge mclk);
    tx_data = b;
    tx_data_valid = 1'b1;
    @(negedge mclk);
    tx_data_valid = 1'b0;
  endtask

  task automatic req(input logic [10:0] id, input logic rtr, input logic [3:0] dlc);
    @(negedge mclk);
    tx_id = id;
    tx_rtr = rtr;
    tx_dlc = dlc;
    tx_req = 1'b1;
    @(negedge mclk);
    tx_req = 1'b0;
    check(64'(tx_ready), 64'h0);
  endtask

  function automatic logic [63:0] pf(input int s, input int w);
    logic [63:0] v;
    int i;
    v = 64'h0;
    for (i = 0; i < w; i++)
      v = {v[62:0], peer_u.rxb[s + i]};
    return v;
  endfunction

  // judge the last frame the far side collected
  task automatic got_frame(input logic [10:0] id, input logic rtr, input logic [3:0] dlc, input logic [63:0] d,
                           input int n);
    check(pf(0, 1), 64'h0);
    check(pf(1, 11), 64'(id));
    check(pf(12, 1), 64'(rtr));
    check(pf(13, 6), 64'(dlc));
    check(pf(19, 8 * n), d >> (64 - 8 * n));
    check(64'(peer_u.crc), 64'h0);
  endtask

  task automatic sc_reset();
    @(negedge mclk);
    check({can_tx_oe, tx_ready, tx_data_ready, tx_done, arb_lost, err_seen, rx_done}, 64'h30);
  endtask

  task automatic sc_fill_send();
    int i;
    for (i = 0; i < 8; i++)
      push(DATA_A[63 - 8 * i -: 8]);
    check(64'(tx_data_ready), 64'h0);
    push(8'hA5);
    req(11'h5A5, 1'b0, 4'h8);
    wait_ev(0, ev[0] + 1);
    got_frame(11'h5A5, 1'b0, 4'h8, DATA_A, 8);
    check(64'(tx_data_ready), 64'h1);
  endtask

  task automatic sc_short_frames();
    int k;
    for (k = 0; k < 2; k++)
    begin
      req(k ? 11'h000 : 11'h7FF, !k, k ? 4'h0 : 4'h3);
      wait_ev(0, ev[0] + 1);
      got_frame(k ? 11'h000 : 11'h7FF, !k, k ? 4'h0 : 4'h3, 64'h0, 0);
    end
  endtask

  task automatic sc_receive_arb();
    int i;
    peer_u.send(11'h123, 1'b0, 4'h8, DATA_A, 1'b0);
    for (i = 0; i < 200 && !peer_u.in_frame; i++)
      @(negedge mclk);
    check(64'(peer_u.in_frame), 64'h1);
    push(8'hBE);
    push(8'hEF);
    req(11'h7F0, 1'b0, 4'h2);
    wait_ev(3, ev[3] + 1);
    check({rx_id, rx_rtr, rx_dlc}, {11'h123, 1'b0, 4'h8});
    check(rxq, DATA_A);
    check(64'(peer_u.ack_seen), 64'h1);
    peer_u.send(11'h00F, 1'b0, 4'h1, 64'hC3 << 56, 1'b0);
    wait_ev(1, ev[1] + 1);
    wait_ev(3, ev[3] + 1);
    check({rx_id, rx_dlc, rxq[7:0]}, {11'h00F, 4'h1, 8'hC3});
    wait_ev(0, ev[0] + 1);
    got_frame(11'h7F0, 1'b0, 4'h2, 64'hBEEF << 48, 2);
  endtask

  task automatic sc_crc_error();
    int t;
    t = ev[3];
    peer_u.send(11'h2AA, 1'b0, 4'h1, 64'h5A << 56, 1'b1);
    wait_ev(2, ev[2] + 1);
    repeat (200) @(negedge mclk);
    check(64'(peer_u.ack_seen), 64'h0);
    check(64'(ev[3]), 64'(t));
  endtask

  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    sc_reset();
    sc_fill_send();
    sc_short_frames();
    sc_receive_arb();
    sc_crc_error();
    finish_test();
  end
endmodule // csfe_node_bench
